// >>> hdl/krpcs_consts.svh
// constants for the coding-layer management register block
// assumes inclusion by the register block only, not by krpcs_pkg.sv
`ifndef KRPCS_CONSTS_SVH
`define KRPCS_CONSTS_SVH

// management device addresses
`define KRPCS_DEVAD_PCS      5'h03
`define KRPCS_DEVAD_PMA      5'h01
// register offsets
`define KRPCS_REG_CTRL       16'h0000
`define KRPCS_REG_STAT1      16'h0001
`define KRPCS_REG_STAT2      16'h0008
`define KRPCS_REG_TRAIN      16'h9001
// control register bit positions
`define KRPCS_CTRL_RESET     15
`define KRPCS_CTRL_LOOP      14
`define KRPCS_CTRL_PWRDN     11
// status register bit positions
`define KRPCS_STAT1_FAULT    7
`define KRPCS_STAT1_LINK     2
`define KRPCS_STAT2_TXF      11
`define KRPCS_STAT2_RXF      10
// fixed read-only contents and reset values
`define KRPCS_STAT1_FIXED    16'h0002
`define KRPCS_STAT2_FIXED    16'h8001
`define KRPCS_TRAIN_RESET    16'h0000
`define KRPCS_TRAIN_SC_MASK  16'h3000
// search-mode field position
`define KRPCS_SEARCH_HI      11
`define KRPCS_SEARCH_LO      9
// frame opcodes
`define KRPCS_OP_ADDR        2'h0
`define KRPCS_OP_WRITE       2'h1
`define KRPCS_OP_READINC     2'h2
// preamble length in bits, last bit counts of header and data
`define KRPCS_PREAMBLE_LEN   6'h20
`define KRPCS_HDR_LAST       6'h0d
`define KRPCS_DATA_LAST      6'h0f

`endif

// >>> hdl/krpcs_pkg.sv
// types shared by the coding-layer management register block
// assumes krpcs_consts.svh holds the register and frame constants
package krpcs_pkg;

	// management frame phases, one-hot
	typedef enum logic [3:0] {
		FR_PREAMBLE = 4'b0001,
		FR_HEADER   = 4'b0010,
		FR_TURN     = 4'b0100,
		FR_DATA     = 4'b1000
	} krpcs_frame_e;

	// controls driven towards the datapath
	typedef struct packed {
		logic       softReset;
		logic       loopEnable;
		logic       powerDown;
		logic [2:0] searchSelect;
		logic       fullRegion;
		logic       autoTrain;
		logic       manualSearch;
	} krpcs_ctrl_s;

	// live conditions reported by the datapath
	typedef struct packed {
		logic txFault;
		logic rxFault;
		logic rxLinkUp;
	} krpcs_status_s;

endpackage : krpcs_pkg

// >>> hdl/krpcs_mgmt_registers.sv
// management registers of the KR coding layer behind a clause 45 mdio slave
// assumes status and krMode come from core logic on clk; mdc, mdio and portAddr are pins
`timescale 1ns/100ps
`include "krpcs_consts.svh"

module krpcs_mgmt_registers (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   sys_rst,
	// management pins
	input  wire logic                   mdc,
	input  wire logic                   mdioIn,
	output logic                        mdioOut,
	output logic                        mdioDriveN,
	input  wire logic [4:0]             portAddr,
	// datapath side
	input  wire logic                   krMode,
	input  wire krpcs_pkg::krpcs_status_s status,
	output krpcs_pkg::krpcs_ctrl_s      ctrl
);

	// register selection, used by both read and write decode
	function automatic logic hit(input logic [4:0] dev, input logic [15:0] addr,
		input logic [4:0] wantDev, input logic [15:0] wantAddr);
		hit = (dev == wantDev) && (addr == wantAddr);
	endfunction : hit

	// pin synchronisers; first stages are read by the second only
	logic [1:0] mdcSync;
	logic [1:0] mdioSync;
	logic [4:0] portMeta;
	logic [4:0] portSync;
	logic       mdcPrev;

	always_ff @(posedge clk) begin
		mdcSync  <= {mdcSync[0], mdc};
		mdioSync <= {mdioSync[0], mdioIn};
		portMeta <= portAddr;
		portSync <= portMeta;
		mdcPrev  <= mdcSync[1];
	end

	// state
	krpcs_pkg::krpcs_frame_e frame, next_frame;
	logic [5:0]  cnt, next_cnt;
	logic [13:0] hdr, next_hdr;
	logic [15:0] dataSh, next_dataSh;
	logic        isRead, next_isRead;
	logic [15:0] addrPcs, next_addrPcs;
	logic [15:0] addrPma, next_addrPma;
	logic        loopEn, next_loopEn;
	logic        pwrDn, next_pwrDn;
	logic [15:0] trainReg, next_trainReg;
	logic        softPulse, next_softPulse;
	logic        txLatch, next_txLatch;
	logic        rxLatch, next_rxLatch;
	logic        linkLatch, next_linkLatch;
	logic        next_mdioOut, next_mdioDriveN;
	krpcs_pkg::krpcs_ctrl_s next_ctrl;

	logic        mdcRise;
	logic        bitIn;
	logic [4:0]  dev;
	logic [15:0] curAddr;
	logic [15:0] readValue;
	logic        faultSummary;

	assign mdcRise      = mdcSync[1] & ~mdcPrev;
	assign bitIn        = mdioSync[1];
	assign dev          = hdr[4:0];
	assign curAddr      = (dev == `KRPCS_DEVAD_PMA) ? addrPma : addrPcs;
	assign faultSummary = status.txFault | status.rxFault | txLatch | rxLatch;

	// read data for the addressed register; reserved bits read zero
	always_comb begin
		readValue = 16'h0000;
		if (hit(dev, curAddr, `KRPCS_DEVAD_PMA, `KRPCS_REG_TRAIN))
			readValue = trainReg;
		else if (hit(dev, curAddr, `KRPCS_DEVAD_PCS, `KRPCS_REG_CTRL)) begin
			readValue[`KRPCS_CTRL_LOOP]  = loopEn;
			readValue[`KRPCS_CTRL_PWRDN] = pwrDn;
		end else if (hit(dev, curAddr, `KRPCS_DEVAD_PCS, `KRPCS_REG_STAT1)) begin
			readValue = `KRPCS_STAT1_FIXED;
			readValue[`KRPCS_STAT1_FAULT] = faultSummary;
			readValue[`KRPCS_STAT1_LINK]  = linkLatch;
		end else if (hit(dev, curAddr, `KRPCS_DEVAD_PCS, `KRPCS_REG_STAT2)) begin
			readValue = `KRPCS_STAT2_FIXED;
			readValue[`KRPCS_STAT2_TXF] = txLatch;
			readValue[`KRPCS_STAT2_RXF] = rxLatch;
		end
	end

	// frame engine, register writes and latched status
	always_comb begin
		logic        clrStat1;
		logic        clrStat2;
		logic        addrOk;
		logic [13:0] newHdr;
		logic [15:0] wData;
		clrStat1        = 1'b0;
		clrStat2        = 1'b0;
		addrOk          = 1'b0;
		newHdr          = {hdr[12:0], bitIn};
		wData           = {dataSh[14:0], bitIn};
		next_frame      = frame;
		next_cnt        = cnt;
		next_hdr        = hdr;
		next_dataSh     = dataSh;
		next_isRead     = isRead;
		next_addrPcs    = addrPcs;
		next_addrPma    = addrPma;
		next_loopEn     = loopEn;
		next_pwrDn      = pwrDn;
		next_trainReg   = trainReg & ~`KRPCS_TRAIN_SC_MASK; // self-clearing pair
		next_softPulse  = 1'b0;
		next_mdioOut    = mdioOut;
		next_mdioDriveN = mdioDriveN;
		if (mdcRise) begin
			unique case (frame)
				krpcs_pkg::FR_PREAMBLE: begin
					if (bitIn)
						next_cnt = (cnt == `KRPCS_PREAMBLE_LEN) ? cnt : cnt + 6'h01;
					else if (cnt == `KRPCS_PREAMBLE_LEN) begin
						next_frame = krpcs_pkg::FR_HEADER;
						next_hdr   = newHdr;
						next_cnt   = 6'h01;
					end else
						next_cnt = 6'h00;
				end
				krpcs_pkg::FR_HEADER: begin
					next_hdr = newHdr;
					next_cnt = cnt + 6'h01;
					if (cnt == `KRPCS_HDR_LAST) begin
						// only device three (in KR mode) and the training register's device answer
						addrOk = (newHdr[13:12] == 2'h0) && (newHdr[9:5] == portSync)
							&& ((newHdr[4:0] == `KRPCS_DEVAD_PCS && krMode)
							|| newHdr[4:0] == `KRPCS_DEVAD_PMA);
						next_cnt    = 6'h00;
						next_isRead = newHdr[11];
						next_frame  = addrOk ? krpcs_pkg::FR_TURN : krpcs_pkg::FR_PREAMBLE;
					end
				end
				krpcs_pkg::FR_TURN: begin
					next_cnt = cnt + 6'h01;
					if (isRead && cnt == 6'h00) begin
						// capture and clear latches in the same cycle; events win over the clear
						next_dataSh     = readValue;
						next_mdioOut    = 1'b0;
						next_mdioDriveN = 1'b0;
						clrStat1 = hit(dev, curAddr, `KRPCS_DEVAD_PCS, `KRPCS_REG_STAT1);
						clrStat2 = hit(dev, curAddr, `KRPCS_DEVAD_PCS, `KRPCS_REG_STAT2);
					end
					if (cnt == 6'h01) begin
						next_frame = krpcs_pkg::FR_DATA;
						next_cnt   = 6'h00;
						if (isRead) begin
							next_mdioOut = dataSh[15];
							next_dataSh  = {dataSh[14:0], 1'b0};
						end
					end
				end
				krpcs_pkg::FR_DATA: begin
					next_cnt = cnt + 6'h01;
					if (isRead) begin
						next_mdioOut = dataSh[15];
						next_dataSh  = {dataSh[14:0], 1'b0};
					end else
						next_dataSh = wData;
					if (cnt == `KRPCS_DATA_LAST) begin
						next_frame      = krpcs_pkg::FR_PREAMBLE;
						next_cnt        = 6'h00;
						next_mdioOut    = 1'b0;
						next_mdioDriveN = 1'b1;
						if (hdr[11:10] == `KRPCS_OP_ADDR) begin
							if (dev == `KRPCS_DEVAD_PMA)
								next_addrPma = wData;
							else
								next_addrPcs = wData;
						end else if (hdr[11:10] == `KRPCS_OP_READINC) begin
							if (dev == `KRPCS_DEVAD_PMA)
								next_addrPma = addrPma + 16'h0001;
							else
								next_addrPcs = addrPcs + 16'h0001;
						end else if (hdr[11:10] == `KRPCS_OP_WRITE) begin
							if (hit(dev, curAddr, `KRPCS_DEVAD_PMA, `KRPCS_REG_TRAIN))
								next_trainReg = wData;
							else if (hit(dev, curAddr, `KRPCS_DEVAD_PCS, `KRPCS_REG_CTRL)) begin
								next_softPulse = wData[`KRPCS_CTRL_RESET];
								next_loopEn    = wData[`KRPCS_CTRL_LOOP];
								next_pwrDn     = wData[`KRPCS_CTRL_PWRDN];
							end
						end
					end
				end
			endcase
		end
		// latched-high faults and latched-low link
		next_txLatch   = status.txFault | (txLatch & ~clrStat2);
		next_rxLatch   = status.rxFault | (rxLatch & ~clrStat2);
		next_linkLatch = status.rxLinkUp & (linkLatch | clrStat1);
		// datapath controls
		next_ctrl.softReset    = next_softPulse;
		next_ctrl.loopEnable   = next_loopEn;
		next_ctrl.powerDown    = next_pwrDn;
		next_ctrl.searchSelect = next_trainReg[`KRPCS_SEARCH_HI:`KRPCS_SEARCH_LO];
		next_ctrl.fullRegion   = ~next_trainReg[11] & next_trainReg[9];
		next_ctrl.autoTrain    = ~next_trainReg[11] & next_trainReg[10];
		next_ctrl.manualSearch = next_trainReg[11];
	end

	// soft reset acts exactly like the reset pin one cycle after the write
	always_ff @(posedge clk) begin
		if (sys_rst || softPulse) begin
			frame      <= krpcs_pkg::FR_PREAMBLE;
			cnt        <= 6'h00;
			hdr        <= 14'h0000;
			dataSh     <= 16'h0000;
			isRead     <= 1'b0;
			addrPcs    <= 16'h0000;
			addrPma    <= 16'h0000;
			loopEn     <= 1'b0;
			pwrDn      <= 1'b0;
			trainReg   <= `KRPCS_TRAIN_RESET;
			softPulse  <= 1'b0;
			txLatch    <= 1'b0;
			rxLatch    <= 1'b0;
			linkLatch  <= 1'b0;
			mdioOut    <= 1'b0;
			mdioDriveN <= 1'b1;
			ctrl       <= '0;
		end else begin
			frame      <= next_frame;
			cnt        <= next_cnt;
			hdr        <= next_hdr;
			dataSh     <= next_dataSh;
			isRead     <= next_isRead;
			addrPcs    <= next_addrPcs;
			addrPma    <= next_addrPma;
			loopEn     <= next_loopEn;
			pwrDn      <= next_pwrDn;
			trainReg   <= next_trainReg;
			softPulse  <= next_softPulse;
			txLatch    <= next_txLatch;
			rxLatch    <= next_rxLatch;
			linkLatch  <= next_linkLatch;
			mdioOut    <= next_mdioOut;
			mdioDriveN <= next_mdioDriveN;
			ctrl       <= next_ctrl;
		end
	end

endmodule : krpcs_mgmt_registers

// >>> sim/krpcs_mgmt_registers_props.sv
// assertions on the coding-layer register block ports
// assumes one clk domain with synchronous active-high sys_rst
`timescale 1ns/100ps

module krpcs_mgmt_registers_props (
	// clock and reset
	input wire logic                   clk,
	input wire logic                   sys_rst,
	// observed outputs
	input wire logic                   mdioOut,
	input wire logic                   mdioDriveN,
	input wire krpcs_pkg::krpcs_ctrl_s ctrl
);
	logic [7:0] drvCnt;
	logic [7:0] next_drvCnt;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// drive burst length, saturating so a stuck enable cannot wrap back under the bound
	always_comb next_drvCnt = (sys_rst || mdioDriveN) ? 8'h00 : drvCnt + {7'h0, drvCnt != 8'hff};
	always_ff @(posedge clk) drvCnt <= next_drvCnt;

	// a read owns the wire for 17 mdc periods, four clks of slack allowed
	a_reset_clears: assert property ($fell(sys_rst) |-> ctrl == '0 && mdioDriveN && !mdioOut)
		else $error("outputs not idle after reset");
	a_soft_single: assert property ($rose(ctrl.softReset) |=> $fell(ctrl.softReset))
		else $error("soft reset pulse longer than one cycle");
	a_soft_clears: assert property (ctrl.softReset |=> ctrl == '0)
		else $error("controls survive soft reset");
	a_search_decode: assert property (ctrl.fullRegion == (!ctrl.searchSelect[2] && ctrl.searchSelect[0])
		&& ctrl.autoTrain == (!ctrl.searchSelect[2] && ctrl.searchSelect[1]))
		else $error("search field decode wrong");
	a_manual_select: assert property (ctrl.manualSearch == ctrl.searchSelect[2])
		else $error("manual search decode wrong");
	a_drive_starts: assert property ($fell(mdioDriveN) |-> !mdioOut)
		else $error("turnaround not driven low");
	a_drive_min: assert property ($fell(mdioDriveN) |=> !mdioDriveN [*8])
		else $error("drive dropped within first mdc period");
	a_drive_bounded: assert property (drvCnt <= 8'h8c)
		else $error("drive held past the data phase");
endmodule : krpcs_mgmt_registers_props

bind krpcs_mgmt_registers krpcs_mgmt_registers_props krpcs_mgmt_registers_props_i (.clk, .sys_rst, .mdioOut,
	.mdioDriveN, .ctrl);

// >>> sim/krpcs_mdio_host.sv
// station-management controller model: makes mdc and resolves the mdio wire
// assumes the device clock; all pin changes land on its falling edge
`timescale 1ns/100ps

module krpcs_mdio_host (
	// device clock
	input  wire logic       clk,
	// device pins
	input  wire logic       mdioOut,
	input  wire logic       mdioDriveN,
	input  wire logic [4:0] portAddr,
	output logic            mdc,
	output logic            mdioIn
);
	logic hostEn;
	logic hostBit;

	// device drive wins; an undriven wire floats to the pull-up level
	assign mdioIn = !mdioDriveN ? mdioOut : (hostEn ? hostBit : 1'b1);

	// mdc stands still low between frames
	initial begin
		mdc = 1'b0;
		hostEn = 1'b0;
		hostBit = 1'b0;
	end

	// one whole frame, msb first; reads release the wire from turnaround on
	task automatic xfer(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] d, output logic [15:0] rd);
		logic [63:0] frame;
		frame = {32'hffffffff, 2'b00, op, portAddr, dev, 2'b10, d};
		for (int i = 63; i >= 0; i--) begin
			@(negedge clk);
			mdc = 1'b0;
			hostEn = !(op[1] && i < 18);
			hostBit = frame[i];
			repeat (4) @(negedge clk);
			mdc = 1'b1;
			rd = {rd[14:0], mdioIn};
			repeat (3) @(negedge clk);
		end
		@(negedge clk);
		mdc = 1'b0;
		hostEn = 1'b0;
	endtask : xfer
endmodule : krpcs_mdio_host

// >>> sim/tb.sv
// self-checking bench for the coding-layer register block
// assumes the host model on the mdio pins; stimulus on clk falling edge
`timescale 1ns/100ps

module tb;
	logic                     clk;
	logic                     sys_rst;
	logic                     mdc;
	logic                     mdioIn;
	logic                     mdioOut;
	logic                     mdioDriveN;
	logic                     krMode;
	krpcs_pkg::krpcs_status_s status;
	krpcs_pkg::krpcs_ctrl_s   ctrl;
	logic [15:0]              rd;
	int                       failures;
	int                       comparisons;
	int                       softSeen;

	krpcs_mgmt_registers krpcs_mgmt_registers_i (.clk, .sys_rst, .mdc, .mdioIn, .mdioOut, .mdioDriveN,
		.portAddr(5'h05), .krMode, .status, .ctrl);
	krpcs_mdio_host krpcs_mdio_host_i (.clk, .mdioOut, .mdioDriveN, .portAddr(5'h05), .mdc, .mdioIn);

	task automatic wrap_up();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : wrap_up

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// address frame then the access; a few clks let a write reach the pins
	task automatic acc(input logic [1:0] op, input logic [4:0] dev, input logic [15:0] a, input logic [15:0] d);
		krpcs_mdio_host_i.xfer(2'h0, dev, a, rd);
		krpcs_mdio_host_i.xfer(op, dev, d, rd);
		repeat (4) @(negedge clk);
	endtask : acc

	task automatic rc(input logic [4:0] dev, input logic [15:0] a, input logic [15:0] exp);
		acc(2'h3, dev, a, 16'h0000);
		check(rd, exp);
	endtask : rc

	// reset values of both status registers, before any event
	task automatic t_reset();
		repeat (4) @(negedge clk);
		rc(5'h03, 16'h0001, 16'h0002);
		rc(5'h03, 16'h0008, 16'h8001);
	endtask : t_reset

	// loopback and power-down write and read back; post-read increment walks ctrl to status one
	task automatic t_ctrl();
		acc(2'h1, 5'h01, 16'h9001, 16'h0000);
		acc(2'h1, 5'h03, 16'h0000, 16'h7fff);
		check({14'h0, ctrl.loopEnable, ctrl.powerDown}, 16'h0003);
		rc(5'h03, 16'h0000, 16'h4800);
		acc(2'h1, 5'h03, 16'h0000, 16'h0000);
		check({14'h0, ctrl.loopEnable, ctrl.powerDown}, 16'h0000);
		acc(2'h2, 5'h03, 16'h0000, 16'h0000);
		check(rd, 16'h0000);
		krpcs_mdio_host_i.xfer(2'h3, 5'h03, 16'h0000, rd);
		check(rd, 16'h0002);
	endtask : t_ctrl

	task automatic t_search();
		for (logic [3:0] c = 4'h0; c < 4'h8; c++) begin
			acc(2'h1, 5'h01, 16'h9001, {4'h0, c[2:0], 9'h000});
			check(16'(ctrl[5:0]), {10'h0, c[2:0], ~c[2] & c[0], ~c[2] & c[1], c[2]});
		end
		rc(5'h01, 16'h9001, 16'h0e00);
		// the self-clearing pair reads zero, every other bit reads back
		acc(2'h1, 5'h01, 16'h9001, 16'hffff);
		rc(5'h01, 16'h9001, 16'hcfff);
	endtask : t_search

	// wrong device address, or kr mode off for device three, leaves the wire to the pull-up
	task automatic t_refuse();
		krMode = 1'b0;
		rc(5'h03, 16'h0008, 16'hffff);
		krMode = 1'b1;
		rc(5'h02, 16'h0008, 16'hffff);
		rc(5'h01, 16'h0005, 16'h0000);
	endtask : t_refuse

	task automatic t_fault();
		status.txFault = 1'b1;
		repeat (2) @(negedge clk);
		status.txFault = 1'b0;
		rc(5'h03, 16'h0001, 16'h0082);
		rc(5'h03, 16'h0008, 16'h8801);
		rc(5'h03, 16'h0008, 16'h8001);
		rc(5'h03, 16'h0001, 16'h0002);
		status.rxFault = 1'b1;
		rc(5'h03, 16'h0001, 16'h0082);
		rc(5'h03, 16'h0008, 16'h8401);
		status.rxFault = 1'b0;
		rc(5'h03, 16'h0008, 16'h8401);
		rc(5'h03, 16'h0001, 16'h0002);
	endtask : t_fault

	task automatic t_link();
		status.rxLinkUp = 1'b1;
		acc(2'h3, 5'h03, 16'h0001, 16'h0000);
		rc(5'h03, 16'h0001, 16'h0006);
		status.rxLinkUp = 1'b0;
		repeat (2) @(negedge clk);
		status.rxLinkUp = 1'b1;
		rc(5'h03, 16'h0001, 16'h0002);
		rc(5'h03, 16'h0001, 16'h0006);
	endtask : t_link

	task automatic t_soft();
		acc(2'h1, 5'h01, 16'h9001, 16'h0800);
		acc(2'h1, 5'h03, 16'h0000, 16'hc800);
		check(16'(softSeen), 16'h0001);
		check(16'(ctrl), 16'h0000);
		rc(5'h01, 16'h9001, 16'h0000);
		rc(5'h03, 16'h0000, 16'h0000);
	endtask : t_soft

	// clock and a soft reset pulse counter, sampled away from the launching edge
	always #25 clk = ~clk;
	always @(negedge clk) if (ctrl.softReset === 1'b1) softSeen++;

	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		krMode = 1'b1;
		status = '0;
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		t_reset();
		t_ctrl();
		t_search();
		t_refuse();
		t_fault();
		t_link();
		t_soft();
		wrap_up();
	end

	// a hung frame cuts the run short
	initial begin
		#3000000;
		failures++;
		wrap_up();
	end
endmodule : tb
